// >>> inc/adcc_pkg.sv
// Package: register map, field positions, reset values and timing constants for the converter control block
`default_nettype none

package adcc_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [2:0] ADDR_CONTROL = 3'h0;
	localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
	localparam logic [2:0] ADDR_RESULT_LOW = 3'h2;
	localparam logic [2:0] ADDR_STATUS = 3'h3;
	localparam logic [2:0] ADDR_START = 3'h4;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int BIT_POWER_ON = 7;
	localparam int BIT_JUSTIFY = 6;
	localparam int BIT_EIGHT_BIT = 5;
	localparam int BIT_SIGNED = 4;
	localparam int PRESCALE_MSB = 3;
	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ----------------------------------------
	// Status register fields
	// ----------------------------------------
	localparam int BIT_STAT_COMPLETE = 0;
	localparam int BIT_STAT_BUSY = 1;

	// ----------------------------------------
	// Converter timing
	// ----------------------------------------
	localparam int RESULT_BITS = 10;
	localparam logic [3:0] SAR_STEPS = 4'hA;
	localparam logic [9:0] RESULT_RESET = 10'h000;

	typedef enum logic [1:0] {
		ADCC_IDLE = 2'b00,
		ADCC_SAMPLE = 2'b01,
		ADCC_CONVERT = 2'b11
	} adcc_state_t;

endpackage : adcc_pkg

`default_nettype wire

// >>> hdl/adcc_prescaler.sv
// Prescaler that turns the bus clock into conversion clock enable pulses
`default_nettype none

module adcc_prescaler (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Control
	input wire logic i_run,
	input wire logic [3:0] i_select,
	// Enable output
	output logic o_tick
);
	import adcc_pkg::*;

	logic [4:0] count;
	logic [4:0] next_count;
	wire logic [4:0] terminal;
	wire logic at_end;

	// Divisor is 2 * (select + 1); terminal count is one below it
	assign terminal = {i_select, 1'b1};
	assign at_end = (count >= terminal);
	assign next_count = at_end ? 5'h00 : count + 5'h01;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= 5'h00;
			o_tick <= 1'b0;
		end else if (!i_run) begin
			count <= 5'h00;
			o_tick <= 1'b0;
		end else begin
			count <= next_count;
			o_tick <= at_end;
		end
	end

endmodule : adcc_prescaler

`default_nettype wire

// >>> hdl/adcc_control.sv
// Converter control register, conversion sequencer and result formatting
//
// Design decisions made here: the strobed register port and the register offsets.
`default_nettype none

module adcc_control (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Analog core
	input wire logic i_comparator,
	output logic o_power_on,
	output logic o_sample,
	output logic [9:0] o_trial,
	output logic o_conv_tick,
	// Status
	output logic o_complete,
	output logic o_busy
);
	import adcc_pkg::*;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] converter_control_reg;
	logic [9:0] result;
	logic [9:0] sar;
	logic [3:0] step;
	logic complete;
	adcc_state_t state;
	adcc_state_t next_state;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire logic wr_control = i_wr && (i_addr == ADDR_CONTROL);
	wire logic wr_start = i_wr && (i_addr == ADDR_START);
	wire logic rd_result = i_rd && ((i_addr == ADDR_RESULT_HIGH) || (i_addr == ADDR_RESULT_LOW));
	wire logic converter_power_on = converter_control_reg[BIT_POWER_ON];
	wire logic result_justify_select = converter_control_reg[BIT_JUSTIFY];
	wire logic eight_bit_resolution = converter_control_reg[BIT_EIGHT_BIT];
	wire logic signed_result_select = converter_control_reg[BIT_SIGNED];
	wire logic [3:0] clock_prescale_select = converter_control_reg[PRESCALE_MSB:0];
	wire logic conv_tick;
	// Any control write, or power-off, kills a conversion in flight
	wire logic abort = wr_control || !converter_power_on;
	wire logic start = wr_start && converter_power_on && !wr_control;
	wire logic last_step = (step == SAR_STEPS - 4'h1);
	// A restart in the last cycle must not leave a half-built result behind
	wire logic finish = (state == ADCC_CONVERT) && conv_tick && last_step && !abort && !start;
	wire logic [9:0] bit_mask = 10'h200 >> step;

	// ----------------------------------------
	// Result formatting
	// ----------------------------------------
	wire logic [1:0] fmt_mode = {eight_bit_resolution, result_justify_select};
	// Signed applies only with left justify; justify set keeps eight-bit results unsigned too
	wire logic use_sign = signed_result_select && !result_justify_select;
	wire logic [9:0] signed_value = {result[9] ^ use_sign, result[8:0]};
	logic [7:0] result_high_byte;
	logic [7:0] result_low_byte;

	function automatic logic [15:0] format_result(input logic [9:0] value, input logic [1:0] mode);
		logic [15:0] packed_bytes;
		packed_bytes = 16'h0000;
		case (mode)
			2'b00: packed_bytes = {value, 6'h00};
			2'b01: packed_bytes = {6'h00, value};
			2'b10, 2'b11: packed_bytes = {value[9:2], 8'h00};
			default: packed_bytes = 16'h0000;
		endcase
		return packed_bytes;
	endfunction : format_result

	// Right justify drops the sign, so the raw value is used there
	wire logic [15:0] formatted = format_result(use_sign ? signed_value : result, fmt_mode);

	assign result_high_byte = formatted[15:8];
	assign result_low_byte = formatted[7:0];

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	adcc_prescaler u_prescaler (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(converter_power_on),
		.i_select(clock_prescale_select),
		.o_tick(conv_tick)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ADCC_IDLE: begin
				if (start) next_state = ADCC_SAMPLE;
			end
			ADCC_SAMPLE: begin
				if (abort) next_state = ADCC_IDLE;
				else if (start) next_state = ADCC_SAMPLE;
				else if (conv_tick) next_state = ADCC_CONVERT;
			end
			ADCC_CONVERT: begin
				if (abort || finish) next_state = ADCC_IDLE;
				else if (start) next_state = ADCC_SAMPLE;
			end
			default: next_state = ADCC_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ADCC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Successive approximation: set trial bit, keep it if comparator says input is higher
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sar <= RESULT_RESET;
			step <= 4'h0;
		end else if (abort || start) begin
			sar <= RESULT_RESET;
			step <= 4'h0;
		end else if (state == ADCC_CONVERT && conv_tick) begin
			if (!i_comparator) sar <= sar & ~bit_mask;
			if (!last_step) sar[8 - step] <= 1'b1;
			if (!i_comparator && !last_step) sar <= (sar & ~bit_mask) | (bit_mask >> 1);
			step <= last_step ? 4'h0 : step + 4'h1;
		end else if (state == ADCC_SAMPLE && conv_tick) begin
			sar <= 10'h200;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			converter_control_reg <= CONTROL_RESET;
		end else if (wr_control) begin
			converter_control_reg <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			result <= RESULT_RESET;
		end else if (finish) begin
			result <= i_comparator ? sar : (sar & ~bit_mask);
		end
	end

	// Completion wins over a clear in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			complete <= 1'b0;
		end else if (finish) begin
			complete <= 1'b1;
		end else if (rd_result || wr_start || !converter_power_on) begin
			complete <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	logic [7:0] next_rdata;

	always_comb begin
		case (i_addr)
			ADDR_CONTROL: next_rdata = converter_control_reg;
			ADDR_RESULT_HIGH: next_rdata = result_high_byte;
			ADDR_RESULT_LOW: next_rdata = result_low_byte;
			ADDR_STATUS: next_rdata = {6'h00, (state != ADCC_IDLE), complete};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_power_on = converter_power_on;
	assign o_sample = (state == ADCC_SAMPLE);
	assign o_trial = sar;
	assign o_conv_tick = conv_tick;
	assign o_complete = complete;
	assign o_busy = (state != ADCC_IDLE);

endmodule : adcc_control

`default_nettype wire

// >>> testbench/adcc_control_checker.sv
// Assertion checker for the converter control block
`default_nettype none
module adcc_control_checker (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// Analog core and status
	input wire logic i_comparator,
	input wire logic o_power_on,
	input wire logic o_sample,
	input wire logic [9:0] o_trial,
	input wire logic o_conv_tick,
	input wire logic o_complete,
	input wire logic o_busy
);
	import adcc_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	logic [7:0] shadow;
	logic [5:0] gap;
	logic gap_ok;
	wire ctl_wr = i_wr && i_addr == ADDR_CONTROL;
	wire rd_hi = i_rd && i_addr == ADDR_RESULT_HIGH;
	wire rd_lo = i_rd && i_addr == ADDR_RESULT_LOW;
	// Spacing is only judged once a full period has passed under one setting
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			shadow <= CONTROL_RESET;
			gap <= 6'h00;
			gap_ok <= 1'b0;
		end else if (ctl_wr) begin
			shadow <= i_wdata;
			gap <= 6'h00;
			gap_ok <= 1'b0;
		end else if (o_conv_tick) begin
			gap <= 6'h01;
			gap_ok <= 1'b1;
		end else begin
			gap <= gap + 6'h01;
		end
	end
	a_power_follows_write: assert property (ctl_wr |=> o_power_on == $past(i_wdata[7]))
		else $error("power bit does not follow control write");
	a_write_aborts_busy: assert property (ctl_wr |=> !o_busy)
		else $error("conversion survives control write");
	a_off_stays_idle: assert property (!o_power_on |-> !o_busy && !o_sample)
		else $error("converter active while powered off");
	a_off_no_tick: assert property (!o_power_on && !$past(o_power_on) |-> !o_conv_tick)
		else $error("conversion tick while powered off");
	a_tick_period_exact: assert property (o_conv_tick && gap_ok |-> gap == (6'(shadow[3:0]) + 6'h01) * 6'h02)
		else $error("conversion tick spacing wrong");
	a_control_readback: assert property (i_rd && i_addr == ADDR_CONTROL |=> o_rdata == shadow)
		else $error("control readback wrong");
	a_eight_low_zero: assert property (rd_lo && shadow[5] |=> o_rdata == 8'h00)
		else $error("low byte not zero in eight-bit mode");
	a_right_high_zero: assert property (rd_hi && shadow[6] && !shadow[5] |=> o_rdata[7:2] == 6'h00)
		else $error("unused high bits set in right justify");
	a_left_low_zero: assert property (rd_lo && !shadow[6] && !shadow[5] |=> o_rdata[5:0] == 6'h00)
		else $error("unused low bits set in left justify");
	cover property (o_complete);
	cover property (ctl_wr && o_busy);
	cover property (o_conv_tick && gap_ok);
endmodule : adcc_control_checker

bind adcc_control adcc_control_checker i_chk (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_comparator(i_comparator), .o_power_on(o_power_on),
	.o_sample(o_sample), .o_trial(o_trial), .o_conv_tick(o_conv_tick), .o_complete(o_complete), .o_busy(o_busy));
`default_nettype wire

// >>> testbench/adcc_control_tb_top.sv
// Testbench for the converter control block
`default_nettype none
module adcc_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import adcc_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_comparator = 1'b0;
	logic [7:0] o_rdata, hi, lo;
	logic [7:0] since = 8'h00;
	logic [7:0] gap_seen = 8'h00;
	logic [9:0] o_trial;
	logic [9:0] tgt = 10'h000;
	logic [9:0] tv [3] = '{10'h3FF, 10'h000, 10'h2A5};
	logic o_power_on, o_sample, o_conv_tick, o_complete, o_busy;
	int n_errors = 0;
	int n_checks = 0;
	always #5 i_clk = ~i_clk;
	adcc_control i_adcc_control (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_comparator(i_comparator), .o_power_on(o_power_on), .o_sample(o_sample),
		.o_trial(o_trial), .o_conv_tick(o_conv_tick), .o_complete(o_complete), .o_busy(o_busy));
	// Comparator stands for an input held at the code in tgt
	always @(posedge i_clk) i_comparator <= (o_trial <= tgt);
	always @(posedge i_clk) begin
		if (o_conv_tick) begin
			gap_seen <= since;
			since <= 8'h01;
		end else begin
			since <= since + 8'h01;
		end
	end
	function automatic logic [15:0] fmt(input logic [2:0] f, input logic [9:0] v);
		logic [9:0] s;
		s = v ^ {f[0] && !f[2], 9'h000};
		if (f[1]) return {s[9:2], 8'h00};
		if (f[2]) return {6'h00, s};
		return {s, 6'h00};
	endfunction : fmt
	task check(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask : check
	task end_of_test;
		$display("TB: errors=%0d checks=%0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_of_test
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic wait_done;
		int k;
		for (k = 0; k < 300 && o_complete !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		if (k == 300) begin
			n_errors++;
			end_of_test();
		end
	endtask : wait_done
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		wr(3'h7, 8'hFF);
		rd(3'h7, hi);
		rd(ADDR_CONTROL, lo);
		check({hi, lo}, 16'h0000);
		// Spacing is checked in bus cycles; picking a legal conversion rate for the real bus clock is software's job
		for (int p = 0; p < 16; p++) begin
			wr(ADDR_CONTROL, 8'h80 | 8'(p));
			repeat (6 * (p + 1) + 4) @(posedge i_clk);
			#1;
			check({8'h00, gap_seen}, 16'(2 * (p + 1)));
		end
		// Every format over full, zero and mid scale from one stored result
		for (int t = 0; t < 3; t++) begin
			tgt <= tv[t];
			wr(ADDR_CONTROL, 8'h80);
			wr(ADDR_START, 8'h00);
			wait_done();
			for (int f = 0; f < 8; f++) begin
				wr(ADDR_CONTROL, {4'h8, 4'h0} | {1'b0, 3'(f), 4'h0});
				rd(ADDR_RESULT_HIGH, hi);
				rd(ADDR_RESULT_LOW, lo);
				check({hi, lo}, fmt(3'(f), tv[t]));
			end
		end
		wr(ADDR_START, 8'h00);
		#1;
		check({14'h0000, o_busy, o_sample}, 16'h0003);
		repeat (6) @(posedge i_clk);
		wr(ADDR_CONTROL, 8'h80);
		#1;
		check({15'h0000, o_busy}, 16'h0000);
		repeat (40) @(posedge i_clk);
		#1;
		check({15'h0000, o_complete}, 16'h0000);
		wr(ADDR_START, 8'h00);
		repeat (6) @(posedge i_clk);
		wr(ADDR_CONTROL, 8'h00);
		#1;
		check({14'h0000, o_power_on, o_busy}, 16'h0000);
		wr(ADDR_START, 8'h00);
		repeat (30) @(posedge i_clk);
		#1;
		check({14'h0000, o_busy, o_conv_tick}, 16'h0000);
		end_of_test();
	end
endmodule : adcc_control_tb_top
`default_nettype wire
